// ==== core/fbh_pkg.sv ====
// Purpose: Shared constants and carrier types for the fault buffer and history manager.
// Assumes: Single 40 MHz system clock, synchronous active-high reset.
// Notes:   Register offsets are byte addresses on the plain register port.
package fbh_pkg;
    // ----------------------------------------------------------------
    // Sizes and field positions
    // ----------------------------------------------------------------
    localparam int           BUF_N          = 8;
    localparam int           HIST_BASE      = 8;
    localparam int           REC_N          = 64;
    localparam int           OVR_N          = 20;
    localparam int           ACK_BIT        = 7;
    localparam int           STAT_FAULT_BIT = 3;
    localparam logic [3:0]   ACK_POWER      = 4'h1;
    localparam logic [3:0]   ACK_IMMED      = 4'h2;
    localparam logic [3:0]   MSG_ALARM      = 4'h2;
    localparam logic [3:0]   MSG_NONE       = 4'h3;
    localparam logic [15:0]  CNT_MAX        = 16'hFFFF;
    localparam logic [31:0]  RESET_WORD     = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CASE_CNT  = 8'h00;
    localparam logic [7:0] OFF_STATUS    = 8'h04;
    localparam logic [7:0] OFF_OLDEST    = 8'h08;
    localparam logic [7:0] OFF_OVR_SEL   = 8'h10;
    localparam logic [7:0] OFF_ACK_CODE  = 8'h14;
    localparam logic [7:0] OFF_ACK_VAL   = 8'h18;
    localparam logic [7:0] OFF_MSG_CODE  = 8'h1C;
    localparam logic [7:0] OFF_MSG_VAL   = 8'h20;
    localparam logic [7:0] OFF_RCT_CODE  = 8'h24;
    localparam logic [7:0] OFF_RCT_VAL   = 8'h28;
    localparam logic [7:0] OFF_HIST_SEL  = 8'h30;
    localparam logic [7:0] OFF_H_CODE    = 8'h34;
    localparam logic [7:0] OFF_H_FIX     = 8'h38;
    localparam logic [7:0] OFF_H_FLT     = 8'h3C;
    localparam logic [7:0] OFF_H_ADAYS   = 8'h40;
    localparam logic [7:0] OFF_H_AMS     = 8'h44;
    localparam logic [7:0] OFF_H_RDAYS   = 8'h48;
    localparam logic [7:0] OFF_H_RMS     = 8'h4C;
    localparam logic [7:0] OFF_H_VALID   = 8'h50;

    // ----------------------------------------------------------------
    // Carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic [15:0] code;
        logic [31:0] val_fix;
        logic [31:0] val_flt;
        logic [15:0] arr_days;
        logic [31:0] arr_ms;
        logic [15:0] rem_days;
        logic [31:0] rem_ms;
    } fbh_rec_s;

    typedef struct packed {
        logic        raise;
        logic        clear;
        logic        hw;
        logic [15:0] code;
        logic [31:0] val_fix;
        logic [31:0] val_flt;
    } fbh_event_s;

    typedef struct packed {
        logic [15:0] days;
        logic [31:0] ms;
    } fbh_time_s;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } fbh_bus_s;
endpackage

// ==== core/fbh_ack_edge.sv ====
// Purpose: Synchronise the two acknowledgment sources and emit one pulse per rising edge of their OR.
// Assumes: Both sources are asynchronous pins.
// Notes:   Pulse appears two edges after the source rises.
`timescale 1ns/1ps
module fbh_ack_edge (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic cw_ack,
    input  wire logic panel_ack,
    output logic      ack_pulse
);
    logic [1:0] s1_reg;
    logic [1:0] s2_reg;
    logic       lvl_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s1_reg  <= 2'h0;
            s2_reg  <= 2'h0;
            lvl_reg <= 1'b0;
        end else if (ce) begin
            s1_reg  <= {panel_ack, cw_ack};
            s2_reg  <= s1_reg;
            lvl_reg <= |s2_reg;
        end
    end

    // Either source counts, but only the rising edge of their OR acts.
    assign ack_pulse = ce & (|s2_reg) & ~lvl_reg;

    pulse_once_a: assert property (@(posedge sys_clk) disable iff (rst)
        ack_pulse |=> !ack_pulse) else $error("ack pulse lasted two cycles");
endmodule // fbh_ack_edge

// ==== core/fbh_fault_mgr.sv ====
// Purpose: Active fault buffer, shifting fault history, acknowledgment and override tables.
// Assumes: Fault events and runtime come from logic on sys_clk; ack sources are pins.
// Notes:   Records 0..7 are the active buffer, 8..63 the history.
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module fbh_fault_mgr (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [15:0]  control_word_one,
    input  wire logic         panel_ack,
    input  fbh_pkg::fbh_event_s fault_evt,
    input  fbh_pkg::fbh_time_s  runtime,
    input  fbh_pkg::fbh_bus_s   bus,
    output logic [31:0]       rdata,
    output logic [15:0]       status_word_one,
    output logic [3:0]        fault_reaction,
    output logic              alarm_pulse
);
    import fbh_pkg::*;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    fbh_rec_s          rec_reg [REC_N];
    logic [BUF_N-1:0]  gone_reg;
    logic [BUF_N-1:0]  pwr_reg;
    logic [BUF_N-1:0]  imm_reg;
    logic              imm_trig_reg;
    logic              last_raise_reg;
    logic [15:0]       case_cnt_reg;
    logic [15:0]       ack_code_reg [OVR_N];
    logic [3:0]        ack_val_reg  [OVR_N];
    logic [15:0]       msg_code_reg [OVR_N];
    logic [3:0]        msg_val_reg  [OVR_N];
    logic [15:0]       rct_code_reg [OVR_N];
    logic [3:0]        rct_val_reg  [OVR_N];
    logic [4:0]        ovr_sel_reg;
    logic [5:0]        hist_sel_reg;
    logic [31:0]       rdata_reg;
    logic [15:0]       status_reg;
    logic [3:0]        reaction_reg;
    logic              alarm_reg;

    logic              ack_pulse;
    logic [BUF_N-1:0]  valid_v;
    logic [BUF_N-1:0]  drop_v;
    logic              ack_go;
    logic              clear_all;
    fbh_rec_s          base_rec [BUF_N];
    logic [BUF_N-1:0]  base_gone;
    logic [BUF_N-1:0]  base_pwr;
    logic [BUF_N-1:0]  base_imm;
    logic [3:0]        base_cnt;
    logic [15:0]       oldest_code;
    logic [3:0]        msg_cls;
    logic [3:0]        ack_type;
    logic              store;
    logic              new_pwr;
    fbh_rec_s          new_rec;

    // Code zero marks an unused table entry, so it never matches.
    function automatic logic [3:0] ovr_find(input logic [15:0] code,
                                            input logic [15:0] codes [OVR_N],
                                            input logic [3:0]  vals  [OVR_N]);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < OVR_N; i++) begin
            if (codes[i] == code && code != 16'h0000) begin
                r = vals[i];
            end
        end
        return r;
    endfunction

    fbh_ack_edge u_ack (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .ce        (ce),
        .cw_ack    (control_word_one[ACK_BIT]),
        .panel_ack (panel_ack),
        .ack_pulse (ack_pulse)
    );

    // ----------------------------------------------------------------
    // Acknowledgment view of the buffer
    // ----------------------------------------------------------------
    always_comb begin
        for (int j = 0; j < BUF_N; j++) begin
            valid_v[j] = rec_reg[j].valid;
        end
    end

    // Power-cycle faults stay even when their cause has gone.
    assign drop_v    = valid_v & gone_reg & ~pwr_reg;
    assign ack_go    = ce & (ack_pulse | imm_trig_reg) & (|drop_v);
    assign clear_all = bus.wr & (bus.addr == OFF_CASE_CNT) & (bus.wdata == RESET_WORD);

    always_comb begin
        base_cnt = 4'h0;
        for (int j = 0; j < BUF_N; j++) begin
            base_rec[j]  = '0;
            base_gone[j] = 1'b0;
            base_pwr[j]  = 1'b0;
            base_imm[j]  = 1'b0;
        end
        for (int j = 0; j < BUF_N; j++) begin
            if (valid_v[j] && !(ack_go && drop_v[j])) begin
                base_rec[base_cnt[2:0]]  = rec_reg[j];
                base_gone[base_cnt[2:0]] = gone_reg[j];
                base_pwr[base_cnt[2:0]]  = pwr_reg[j];
                base_imm[base_cnt[2:0]]  = imm_reg[j];
                base_cnt                 = base_cnt + 4'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // New fault classification
    // ----------------------------------------------------------------
    assign msg_cls  = ovr_find(fault_evt.code, msg_code_reg, msg_val_reg);
    assign ack_type = ovr_find(fault_evt.code, ack_code_reg, ack_val_reg);
    assign store    = fault_evt.raise & (msg_cls != MSG_ALARM) & (msg_cls != MSG_NONE);
    assign new_pwr  = fault_evt.hw | (ack_type == ACK_POWER);
    assign new_rec  = '{valid: 1'b1, code: fault_evt.code, val_fix: fault_evt.val_fix,
                        val_flt: fault_evt.val_flt, arr_days: runtime.days, arr_ms: runtime.ms,
                        rem_days: 16'h0000, rem_ms: 32'h0000_0000};

    // ----------------------------------------------------------------
    // Record array
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst || (ce && clear_all)) begin
            for (int i = 0; i < REC_N; i++) begin
                rec_reg[i] <= '0;
            end
            gone_reg     <= '0;
            pwr_reg      <= '0;
            imm_reg      <= '0;
            imm_trig_reg <= 1'b0;
        end else if (ce) begin
            if (ack_go) begin
                for (int i = REC_N - 1; i >= HIST_BASE + BUF_N; i--) begin
                    rec_reg[i] <= rec_reg[i - BUF_N];
                end
                for (int j = 0; j < BUF_N; j++) begin
                    // Empty buffer slots copy as empty history slots.
                    rec_reg[HIST_BASE + j] <= rec_reg[j];
                    if (drop_v[j]) begin
                        rec_reg[HIST_BASE + j].rem_days <= runtime.days;
                        rec_reg[HIST_BASE + j].rem_ms   <= runtime.ms;
                    end
                end
            end
            for (int j = 0; j < BUF_N; j++) begin
                rec_reg[j] <= base_rec[j];
                pwr_reg[j] <= base_pwr[j];
                imm_reg[j] <= base_imm[j];
                gone_reg[j] <= base_gone[j] |
                               (fault_evt.clear && base_rec[j].valid && base_rec[j].code == fault_evt.code);
            end
            if (store) begin
                if (base_cnt < 4'(BUF_N)) begin
                    rec_reg[base_cnt[2:0]]  <= new_rec;
                    gone_reg[base_cnt[2:0]] <= 1'b0;
                    pwr_reg[base_cnt[2:0]]  <= new_pwr;
                    imm_reg[base_cnt[2:0]]  <= (ack_type == ACK_IMMED) & ~new_pwr;
                end else begin
                    // The last entry slides into the next-to-last slot.
                    rec_reg[BUF_N-2]  <= base_rec[BUF_N-1];
                    gone_reg[BUF_N-2] <= base_gone[BUF_N-1];
                    pwr_reg[BUF_N-2]  <= base_pwr[BUF_N-1];
                    imm_reg[BUF_N-2]  <= base_imm[BUF_N-1];
                    rec_reg[BUF_N-1]  <= new_rec;
                    gone_reg[BUF_N-1] <= 1'b0;
                    pwr_reg[BUF_N-1]  <= new_pwr;
                    imm_reg[BUF_N-1]  <= (ack_type == ACK_IMMED) & ~new_pwr;
                end
            end
            imm_trig_reg <= 1'b0;
            for (int j = 0; j < BUF_N; j++) begin
                if (fault_evt.clear && base_rec[j].valid && base_imm[j] && base_rec[j].code == fault_evt.code) begin
                    imm_trig_reg <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Fault case counter
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst || (ce && clear_all)) begin
            case_cnt_reg   <= 16'h0000;
            last_raise_reg <= 1'b0;
        end else if (ce) begin
            last_raise_reg <= store;
            // A new case wins over an acknowledgment in the same cycle.
            if (store && !last_raise_reg) begin
                case_cnt_reg <= ack_go ? 16'h0001 : (case_cnt_reg == CNT_MAX ? CNT_MAX : case_cnt_reg + 16'h0001);
            end else if (ack_go) begin
                case_cnt_reg <= 16'h0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // Override tables and selectors
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ovr_sel_reg  <= 5'h00;
            hist_sel_reg <= 6'h00;
            for (int i = 0; i < OVR_N; i++) begin
                ack_code_reg[i] <= 16'h0000;
                ack_val_reg[i]  <= 4'h0;
                msg_code_reg[i] <= 16'h0000;
                msg_val_reg[i]  <= 4'h0;
                rct_code_reg[i] <= 16'h0000;
                rct_val_reg[i]  <= 4'h0;
            end
        end else if (ce && bus.wr) begin
            if (bus.addr == OFF_OVR_SEL && bus.wdata < 32'(OVR_N)) begin
                ovr_sel_reg <= bus.wdata[4:0];
            end
            if (bus.addr == OFF_HIST_SEL) begin
                hist_sel_reg <= bus.wdata[5:0];
            end
            unique case (bus.addr)
                OFF_ACK_CODE: ack_code_reg[ovr_sel_reg] <= bus.wdata[15:0];
                OFF_ACK_VAL:  ack_val_reg[ovr_sel_reg]  <= bus.wdata[3:0];
                OFF_MSG_CODE: msg_code_reg[ovr_sel_reg] <= bus.wdata[15:0];
                OFF_MSG_VAL:  msg_val_reg[ovr_sel_reg]  <= bus.wdata[3:0];
                OFF_RCT_CODE: rct_code_reg[ovr_sel_reg] <= bus.wdata[15:0];
                OFF_RCT_VAL:  rct_val_reg[ovr_sel_reg]  <= bus.wdata[3:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Status, reaction, alarm and read data
    // ----------------------------------------------------------------
    always_comb begin
        oldest_code = 16'h0000;
        for (int j = BUF_N - 1; j >= 0; j--) begin
            if (valid_v[j] && !gone_reg[j]) begin
                oldest_code = rec_reg[j].code;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status_reg   <= 16'h0000;
            reaction_reg <= 4'h0;
            alarm_reg    <= 1'b0;
            rdata_reg    <= 32'h0000_0000;
        end else if (ce) begin
            status_reg[STAT_FAULT_BIT] <= |valid_v;
            alarm_reg <= fault_evt.raise & (msg_cls == MSG_ALARM);
            if (store) begin
                reaction_reg <= ovr_find(fault_evt.code, rct_code_reg, rct_val_reg);
            end
            rdata_reg <= 32'h0000_0000;
            if (bus.rd) begin
                unique case (bus.addr)
                    OFF_CASE_CNT: rdata_reg <= {16'h0000, case_cnt_reg};
                    OFF_STATUS:   rdata_reg <= {16'h0000, status_reg};
                    OFF_OLDEST:   rdata_reg <= {16'h0000, oldest_code};
                    OFF_OVR_SEL:  rdata_reg <= {27'h0, ovr_sel_reg};
                    OFF_ACK_CODE: rdata_reg <= {16'h0000, ack_code_reg[ovr_sel_reg]};
                    OFF_ACK_VAL:  rdata_reg <= {28'h0, ack_val_reg[ovr_sel_reg]};
                    OFF_MSG_CODE: rdata_reg <= {16'h0000, msg_code_reg[ovr_sel_reg]};
                    OFF_MSG_VAL:  rdata_reg <= {28'h0, msg_val_reg[ovr_sel_reg]};
                    OFF_RCT_CODE: rdata_reg <= {16'h0000, rct_code_reg[ovr_sel_reg]};
                    OFF_RCT_VAL:  rdata_reg <= {28'h0, rct_val_reg[ovr_sel_reg]};
                    OFF_HIST_SEL: rdata_reg <= {26'h0, hist_sel_reg};
                    OFF_H_CODE:   rdata_reg <= {16'h0000, rec_reg[hist_sel_reg].code};
                    OFF_H_FIX:    rdata_reg <= rec_reg[hist_sel_reg].val_fix;
                    OFF_H_FLT:    rdata_reg <= rec_reg[hist_sel_reg].val_flt;
                    OFF_H_ADAYS:  rdata_reg <= {16'h0000, rec_reg[hist_sel_reg].arr_days};
                    OFF_H_AMS:    rdata_reg <= rec_reg[hist_sel_reg].arr_ms;
                    OFF_H_RDAYS:  rdata_reg <= {16'h0000, rec_reg[hist_sel_reg].rem_days};
                    OFF_H_RMS:    rdata_reg <= rec_reg[hist_sel_reg].rem_ms;
                    OFF_H_VALID:  rdata_reg <= {31'h0, rec_reg[hist_sel_reg].valid};
                    default:      rdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign rdata           = rdata_reg;
    assign status_word_one = status_reg;
    assign fault_reaction  = reaction_reg;
    assign alarm_pulse     = alarm_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_ack_go;
        ack_go && !clear_all;
    endsequence
    sequence s_ack_idle;
        ce && ack_pulse && !(|drop_v) && !clear_all && !store;
    endsequence

    clear_wipe_a: assert property (ce && clear_all |=> !rec_reg[0].valid && !rec_reg[8].valid
        && !rec_reg[63].valid && case_cnt_reg == 16'h0000) else $error("clear did not wipe records");
    ack_noeff_a: assert property (s_ack_idle |=> $stable(rec_reg[8]) && $stable(rec_reg[0]))
        else $error("ineffective ack changed records");
    hist_shift_a: assert property (s_ack_go |=> rec_reg[16] == $past(rec_reg[8])
        && rec_reg[63] == $past(rec_reg[55])) else $error("history not shifted by eight");
    hist_copy_a: assert property (s_ack_go |=> rec_reg[8].code == $past(rec_reg[0].code)
        && rec_reg[15].valid == $past(rec_reg[7].valid)) else $error("buffer not copied to history");
    stamp_time_a: assert property (s_ack_go ##0 drop_v[0] |=> rec_reg[8].rem_ms == $past(runtime.ms)
        && rec_reg[8].rem_days == $past(runtime.days)) else $error("removal time not stamped");
    status_bit_a: assert property (ce && (|valid_v) |=> status_word_one[3])
        else $error("status bit missing while fault active");
    pwr_hold_a: assert property (ce && valid_v[0] && pwr_reg[0] && !clear_all |=> rec_reg[0].valid)
        else $error("power-cycle fault was removed");
    case_count_a: assert property (ce && store && !last_raise_reg && !ack_go && !clear_all
        && case_cnt_reg < 16'h00FF |=> case_cnt_reg == $past(case_cnt_reg) + 16'h0001)
        else $error("fault case not counted");
    alarm_route_a: assert property (ce && fault_evt.raise && msg_cls == MSG_ALARM |=> alarm_pulse)
        else $error("alarm class not routed");
endmodule // fbh_fault_mgr

// ==== bench/fbh_ack_partner.sv ====
// Purpose: Controller and operator panel model that raises acknowledgment requests.
// Assumes: Requests are levels commanded by the testbench.
// Notes:   Control word bits other than the request bit are held low.
`timescale 1ns/1ps
module fbh_ack_partner (
    input  wire logic        sys_clk,
    input  wire logic        cw_req,
    input  wire logic        panel_req,
    output logic [15:0]      control_word_one,
    output logic             panel_ack
);
    import fbh_pkg::*;
    // The panel output is registered so that it changes only after an edge, like a real pin driver.
    always_ff @(posedge sys_clk) begin
        control_word_one <= 16'h0000 | (16'(cw_req) << ACK_BIT);
        panel_ack        <= panel_req;
    end
endmodule // fbh_ack_partner

// ==== bench/fbh_fault_mgr_tb.sv ====
// Purpose: Self-checking bench for the fault buffer and history manager.
// Assumes: Runtime stands still, so every removal stamp must equal it.
// Notes:   Acknowledgments are held at least six cycles to cover the synchroniser delay.
`timescale 1ns/1ps
module fbh_fault_mgr_tb;
    import fbh_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, cw_req = 1'b0, panel_req = 1'b0, panel_ack, alarm_pulse;
    logic [15:0] control_word_one, status_word_one;
    logic [31:0] rdata, d;
    logic [3:0]  fault_reaction;
    fbh_event_s  fault_evt = '0;
    fbh_time_s   runtime = {16'h0012, 32'h0000_3456};
    fbh_bus_s    bus = '0;
    int          mismatches = 0, n_compared = 0;
    always #12.5 sys_clk = ~sys_clk;
    fbh_ack_partner i_fbh_ack_partner (.sys_clk(sys_clk), .cw_req(cw_req), .panel_req(panel_req),
        .control_word_one(control_word_one), .panel_ack(panel_ack));
    fbh_fault_mgr i_fbh_fault_mgr (.sys_clk(sys_clk), .rst(rst), .ce(ce), .control_word_one(control_word_one),
        .panel_ack(panel_ack), .fault_evt(fault_evt), .runtime(runtime), .bus(bus), .rdata(rdata),
        .status_word_one(status_word_one), .fault_reaction(fault_reaction), .alarm_pulse(alarm_pulse));
    task automatic test_done;
        if (mismatches == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk) bus <= {a, v, 1'b1, 1'b0};
        @(posedge sys_clk) bus <= '0;
    endtask
    task automatic reg_is(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk) bus <= {a, 32'h0, 1'b0, 1'b1};
        @(posedge sys_clk) bus <= '0;
        #1 chk(what, rdata, exp);
    endtask
    task automatic see(input string what, input logic [7:0] idx, input logic [7:0] a, input logic [31:0] exp);
        bus_wr(OFF_HIST_SEL, {24'h0, idx});
        reg_is(what, a, exp);
    endtask
    task automatic evt(input logic r, input logic c, input logic h, input logic [15:0] code);
        @(posedge sys_clk) fault_evt <= {r, c, h, code, {16'h0, code}, 32'h0};
        @(posedge sys_clk) fault_evt <= '0;
    endtask
    // Hangs are cut well past the few hundred cycles the sequence needs.
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        test_done;
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        reg_is("status_idle", OFF_STATUS, 32'h0);
        evt(1'b1, 1'b0, 1'b0, 16'h0101);
        repeat (2) @(posedge sys_clk);
        evt(1'b1, 1'b0, 1'b1, 16'h0202);
        reg_is("cases_two", OFF_CASE_CNT, 32'h2);
        reg_is("status_fault", OFF_STATUS, 32'h8);
        see("fixed_val", 8'd0, OFF_H_FIX, 32'h0101);
        cw_req <= 1'b1;
        repeat (6) @(posedge sys_clk);
        cw_req <= 1'b0;
        see("ack_no_gone", 8'd8, OFF_H_VALID, 32'h0);
        evt(1'b0, 1'b1, 1'b0, 16'h0101);
        cw_req <= 1'b1;
        repeat (6) @(posedge sys_clk);
        see("hist8_code", 8'd8, OFF_H_CODE, 32'h0101);
        see("hist9_code", 8'd9, OFF_H_CODE, 32'h0202);
        see("hist10_empty", 8'd10, OFF_H_VALID, 32'h0);
        see("rem_ms", 8'd8, OFF_H_RMS, 32'h3456);
        see("rem_days", 8'd8, OFF_H_RDAYS, 32'h12);
        see("live_rem_ms", 8'd9, OFF_H_RMS, 32'h0);
        see("buf0_hw", 8'd0, OFF_H_CODE, 32'h0202);
        reg_is("oldest", OFF_OLDEST, 32'h0202);
        reg_is("cases_zero", OFF_CASE_CNT, 32'h0);
        evt(1'b1, 1'b0, 1'b0, 16'h0303);
        evt(1'b0, 1'b1, 1'b0, 16'h0303);
        repeat (6) @(posedge sys_clk);
        see("held_once", 8'd8, OFF_H_CODE, 32'h0101);
        cw_req <= 1'b0;
        repeat (4) @(posedge sys_clk);
        panel_req <= 1'b1;
        repeat (6) @(posedge sys_clk);
        panel_req <= 1'b0;
        see("panel_ack", 8'd9, OFF_H_CODE, 32'h0303);
        see("shift16", 8'd16, OFF_H_CODE, 32'h0101);
        bus_wr(OFF_CASE_CNT, 32'h0);
        see("erase_hist", 8'd16, OFF_H_VALID, 32'h0);
        reg_is("erase_buf", OFF_STATUS, 32'h0);
        bus_wr(OFF_OVR_SEL, 32'h0);
        bus_wr(OFF_MSG_CODE, 32'h0404);
        bus_wr(OFF_MSG_VAL, 32'h2);
        bus_wr(OFF_OVR_SEL, 32'h1);
        bus_wr(OFF_MSG_CODE, 32'h0606);
        bus_wr(OFF_MSG_VAL, 32'h3);
        bus_wr(OFF_ACK_CODE, 32'h0505);
        bus_wr(OFF_ACK_VAL, 32'h2);
        bus_wr(OFF_RCT_CODE, 32'h0505);
        bus_wr(OFF_RCT_VAL, 32'h5);
        bus_wr(OFF_OVR_SEL, 32'h14);
        reg_is("sel_refused", OFF_OVR_SEL, 32'h1);
        reg_is("ack_val", OFF_ACK_VAL, 32'h2);
        evt(1'b1, 1'b0, 1'b0, 16'h0404);
        #1 chk("alarm_pulse", {31'h0, alarm_pulse}, 32'h1);
        evt(1'b1, 1'b0, 1'b0, 16'h0606);
        #1 chk("alarm_drop", {31'h0, alarm_pulse}, 32'h0);
        chk("not_stored", {16'h0, status_word_one}, 32'h0);
        evt(1'b1, 1'b0, 1'b0, 16'h0505);
        #1 chk("reaction", {28'h0, fault_reaction}, 32'h5);
        evt(1'b0, 1'b1, 1'b0, 16'h0505);
        see("imm_ack", 8'd8, OFF_H_CODE, 32'h0505);
        reg_is("imm_gone", OFF_STATUS, 32'h0);
        bus_wr(OFF_OVR_SEL, 32'h2);
        bus_wr(OFF_ACK_CODE, 32'h0707);
        bus_wr(OFF_ACK_VAL, 32'h1);
        evt(1'b1, 1'b0, 1'b0, 16'h0707);
        evt(1'b0, 1'b1, 1'b0, 16'h0707);
        panel_req <= 1'b1;
        repeat (6) @(posedge sys_clk);
        panel_req <= 1'b0;
        see("pwr_kept", 8'd0, OFF_H_CODE, 32'h0707);
        see("pwr_no_ack", 8'd8, OFF_H_CODE, 32'h0505);
        for (int k = 1; k <= 8; k++) evt(1'b1, 1'b0, 1'b0, 16'h0A00 + 16'(k));
        see("ovf_slot6", 8'd6, OFF_H_CODE, 32'h0A07);
        see("ovf_slot7", 8'd7, OFF_H_CODE, 32'h0A08);
        chk("status_port", {16'h0, status_word_one}, 32'h8);
        @(posedge sys_clk) ce <= 1'b0;
        evt(1'b1, 1'b0, 1'b0, 16'h0B0B);
        ce <= 1'b1;
        see("ce_freeze", 8'd7, OFF_H_CODE, 32'h0A08);
        test_done;
    end
endmodule // fbh_fault_mgr_tb
